//--- logic/csr_pkg.sv
// constants shared by the clock, sleep and reset control block
// assumes a single 200 MHz system clock and an asynchronous active-low reset
//
// Contract
// - compatible mode: one instruction per four clocks
// - turbo mode: one instruction per clock
// - clocking mode from 12-bit config word
// - internal RC 4 MHz divided by two-bit field
// - RC internal/external plus seven crystal modes
// - external clock accepted in any crystal mode
// - reset on power-up, wake, brown-out, watchdog, clear
// - reset loads program counter with top address
// - sleep halts execution until wakeup
// - power down gates the core clock enable; watchdog, oscillator ticks and bus keep running
// - watchdog counts through sleep on own clock
// - sleep with watchdog sets timeout, clears power-down
// - watchdog timeout in sleep wakes and resets
// - extended bit keeps or stops clock asleep
// - wake on watchdog, pin edge, clear, brown-out
// - wakeup sets both flags, restarts at reset
package csr_pkg;
	// config word layout
	localparam int CFG_WIDTH      = 12;
	localparam int CFG_OSC_LSB    = 0;   // oscillator mode, 4 bits
	localparam int CFG_OSC_W      = 4;
	localparam int CFG_DIV_LSB    = 4;   // rc_divide_select, 2 bits
	localparam int CFG_TURBO_BIT  = 6;   // 1 = one instruction per clock
	localparam int CFG_WDT_EN_BIT = 7;
	localparam logic [11:0] CFG_RESET = 12'h0C0;
	// extended config word layout
	localparam int XCFG_SLPCLK_OFF_BIT = 0; // active low: 0 keeps clock asleep
	localparam logic [11:0] XCFG_RESET = 12'h001;
	// oscillator mode codes
	localparam logic [3:0] OSC_INT_RC = 4'h0;
	localparam logic [3:0] OSC_EXT_RC = 4'h1;
	localparam logic [3:0] OSC_LOWP1  = 4'h2;
	localparam logic [3:0] OSC_LOWP2  = 4'h3;
	localparam logic [3:0] OSC_NORM1  = 4'h4;
	localparam logic [3:0] OSC_NORM2  = 4'h5;
	localparam logic [3:0] OSC_FAST1  = 4'h6;
	localparam logic [3:0] OSC_FAST2  = 4'h7;
	localparam logic [3:0] OSC_FAST3  = 4'h8;
	// program counter reset values
	localparam logic [11:0] PC_TOP_SMALL = 12'h7FF;
	localparam logic [11:0] PC_TOP_LARGE = 12'hFFF;
	// instruction rate
	localparam int COMPAT_DIVIDE = 4;
	// internal RC: nominal 4 MHz, slowest 31.25 kHz (divide 128)
	localparam int RC_NOMINAL_KHZ = 4000;
	localparam int RC_MIN_HZ      = 31250;
	// watchdog reset pulse width on the core clock
	localparam int RESET_HOLD_NS  = 20;
	localparam int CLOCK_MHZ      = 200;
	localparam int RESET_HOLD_CYC =
		(RESET_HOLD_NS * CLOCK_MHZ + 999) / 1000;
	// register map
	localparam logic [3:0] REG_CONFIG  = 4'h0;
	localparam logic [3:0] REG_XCONFIG = 4'h1;
	localparam logic [3:0] REG_STATUS  = 4'h2;
	localparam logic [3:0] REG_IRQ_ST  = 4'h3;
	localparam logic [3:0] REG_IRQ_MSK = 4'h4;
	localparam logic [3:0] REG_CONTROL = 4'h5;
	// interrupt bits
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_WDT  = 1;
	localparam int IRQ_SLP  = 2;
	localparam int IRQ_W    = 3;
	typedef enum {PWR_RUN, PWR_SLEEP, PWR_RESET} csr_pwr_e;
endpackage : csr_pkg

//--- logic/csr_watchdog.sv
// watchdog counter on its own oscillator, runs through power down
// assumes wdtTick is a synchronised single-cycle tick on clock
`timescale 1ns/1ps
module csr_watchdog #(
	parameter int COUNT_W = 8
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// control
	input  wire logic               enable,
	input  wire logic               wdtTick,
	input  wire logic               kick,
	// result
	output logic                    timeout
);
	import csr_pkg::*;
	// a one-bit counter cannot tell a tick from an overflow
	if (COUNT_W < 2) begin : gBadWidth
		$error("COUNT_W too small");
	end
	logic [COUNT_W-1:0] count_reg, count_next;
	logic               timeout_reg, timeout_next;

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// counts ticks of its own oscillator, never gated by sleep
	always_comb begin
		count_next   = count_reg;
		timeout_next = 1'b0;
		if (!enable || kick) begin
			count_next = '0;
		end else if (wdtTick) begin
			count_next = count_reg + 1'b1;
			if (&count_reg) begin
				timeout_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_reg   <= '0;
			timeout_reg <= 1'b0;
		end else begin
			count_reg   <= count_next;
			timeout_reg <= timeout_next;
		end
	end

	assign timeout = timeout_reg;
endmodule : csr_watchdog

//--- logic/csr_control.sv
// clock, sleep and reset control with Avalon-MM register slave
// assumes pins and the watchdog oscillator are asynchronous to clock
`timescale 1ns/1ps
module csr_control #(
	parameter logic [11:0] PC_TOP = 12'h7FF,
	parameter int          WDT_W  = 8,
	// divide factor per rc_divide_select code, log2 form
	parameter logic [2:0]  RC_DIV_LOG2 [4] = '{3'd0, 3'd2, 3'd4, 3'd7}
) (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst_n,
	// avalon-mm slave
	input  wire logic [3:0]         address,
	input  wire logic               read,
	input  wire logic               write,
	input  wire logic [31:0]        writedata,
	output logic      [31:0]        readdata,
	output logic                    waitrequest,
	output logic                    irq,
	// pins and reset sources
	input  wire logic               osc_in_pin,
	input  wire logic               intRcClk,
	input  wire logic               wdtOscClk,
	input  wire logic               master_clear_n,
	input  wire logic               brownOut,
	input  wire logic               portWakeEvt,
	// core side
	input  wire logic               sleepExec,
	input  wire logic               wdtClear,
	output logic                    instrCycle,
	output logic                    coreClkEn,
	output logic                    coreReset,
	output logic      [11:0]        pcLoad,
	output logic                    watchdog_timeout_flag,
	output logic                    power_down_flag
);
	import csr_pkg::*;
	if (PC_TOP != PC_TOP_SMALL && PC_TOP != PC_TOP_LARGE) begin : gBadTop
		$error("PC_TOP must be a top address");
	end

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [4:0] syncA_reg, syncB_reg, syncB_d;
	wire  [4:0] rawIn = {osc_in_pin, intRcClk, wdtOscClk,
	                     master_clear_n, brownOut};
	// two stages, then an edge register on the second stage only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// idle levels: clear released, no brown-out
			syncA_reg <= 5'h02;
			syncB_reg <= 5'h02;
			syncB_d   <= 5'h02;
		end else begin
			syncA_reg <= rawIn;
			syncB_reg <= syncA_reg;
			syncB_d   <= syncB_reg;
		end
	end
	wire extRise = syncB_reg[4] & ~syncB_d[4];
	wire rcRise  = syncB_reg[3] & ~syncB_d[3];
	wire wdtRise = syncB_reg[2] & ~syncB_d[2];
	wire clrLow  = ~syncB_reg[1];
	wire brown   = syncB_reg[0];

	// ----------------------------------------
	// configuration and registers
	// ----------------------------------------
	logic [11:0] cfg_reg, cfg_next, xcfg_reg, xcfg_next;
	logic        progMode_reg, progMode_next;
	logic [IRQ_W-1:0] irqSt_reg, irqSt_next, irqMsk_reg, irqMsk_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        wait_reg, wait_next;
	logic        irq_reg, irq_next;
	logic [IRQ_W-1:0] evt;

	function automatic logic isCrystal(input logic [3:0] m);
		isCrystal = (m >= OSC_LOWP1) && (m <= OSC_FAST3);
	endfunction : isCrystal

	wire [3:0] oscMode = cfg_reg[CFG_OSC_LSB +: CFG_OSC_W];
	wire [1:0] divSel  = cfg_reg[CFG_DIV_LSB +: 2];
	wire       turbo   = cfg_reg[CFG_TURBO_BIT];
	wire       wdtEn   = cfg_reg[CFG_WDT_EN_BIT];
	wire       sleepClkKeep = ~xcfg_reg[XCFG_SLPCLK_OFF_BIT];
	wire       access  = (read | write) & wait_reg;

	// one wait state per access, then the answer
	always_comb begin
		cfg_next      = cfg_reg;
		xcfg_next     = xcfg_reg;
		progMode_next = progMode_reg;
		irqMsk_next   = irqMsk_reg;
		rdata_next    = rdata_reg;
		wait_next     = 1'b1;
		// set wins over clear: events are ORed in after the clear
		irqSt_next    = irqSt_reg;
		if (access && write && address == REG_IRQ_ST) begin
			irqSt_next = irqSt_reg & ~writedata[IRQ_W-1:0];
		end
		irqSt_next = irqSt_next | evt;
		if (access) begin
			wait_next = 1'b0;
			if (write) begin
				case (address)
					// config only writable while programming
					REG_CONFIG:  if (progMode_reg) cfg_next = writedata[11:0];
					REG_XCONFIG: if (progMode_reg) xcfg_next = writedata[11:0];
					REG_IRQ_MSK: irqMsk_next = writedata[IRQ_W-1:0];
					REG_CONTROL: progMode_next = writedata[0];
					default: ;
				endcase
			end else begin
				case (address)
					REG_CONFIG:  rdata_next = {20'h00000, cfg_reg};
					REG_XCONFIG: rdata_next = {20'h00000, xcfg_reg};
					REG_STATUS:  rdata_next = {30'h00000000,
						watchdog_timeout_flag, power_down_flag};
					REG_IRQ_ST:  rdata_next = {29'h00000000, irqSt_reg};
					REG_IRQ_MSK: rdata_next = {29'h00000000, irqMsk_reg};
					REG_CONTROL: rdata_next = {31'h00000000, progMode_reg};
					default:     rdata_next = 32'h00000000;
				endcase
			end
		end
		irq_next = |(irqSt_next & irqMsk_next);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg      <= CFG_RESET;
			xcfg_reg     <= XCFG_RESET;
			progMode_reg <= 1'b0;
			irqSt_reg    <= '0;
			irqMsk_reg   <= '0;
			rdata_reg    <= 32'h00000000;
			wait_reg     <= 1'b1;
			irq_reg      <= 1'b0;
		end else begin
			cfg_reg      <= cfg_next;
			xcfg_reg     <= xcfg_next;
			progMode_reg <= progMode_next;
			irqSt_reg    <= irqSt_next;
			irqMsk_reg   <= irqMsk_next;
			rdata_reg    <= rdata_next;
			wait_reg     <= wait_next;
			irq_reg      <= irq_next;
		end
	end

	// ----------------------------------------
	// oscillator tick selection
	// ----------------------------------------
	logic [6:0] rcDiv_reg, rcDiv_next;
	logic [1:0] phase_reg, phase_next;
	logic       instr_reg, instr_next;
	logic       oscTick;
	wire  [6:0] rcMask = 7'((8'h01 << RC_DIV_LOG2[divSel]) - 8'h01);

	// pick the tick source; any crystal mode takes osc_in the same way
	always_comb begin
		rcDiv_next = rcDiv_reg;
		oscTick    = 1'b0;
		if (oscMode == OSC_INT_RC) begin
			// >= so a count left from a longer divide wraps at once
			if (rcRise) begin
				rcDiv_next = (rcDiv_reg >= rcMask) ? 7'h00 : rcDiv_reg + 7'h01;
				oscTick = (rcDiv_reg >= rcMask);
			end
		end else if (oscMode == OSC_EXT_RC || isCrystal(oscMode)) begin
			oscTick = extRise;
		end
	end

	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	csr_pwr_e    state_reg, state_next;
	logic        to_reg, to_next, pwrDn_reg, pwrDn_next;
	logic [11:0] pc_reg, pc_next;
	logic        rst_reg, rst_next;
	logic        clkEn_reg, clkEn_next;
	logic [3:0]  hold_reg, hold_next;
	logic        wdtTimeout;
	logic        wakeSrc;

	csr_watchdog #(
		.COUNT_W (WDT_W)
	) uWdt (
		.clock   (clock),
		.rst_n   (rst_n),
		.enable  (wdtEn),
		.wdtTick (wdtRise),
		.kick    (wdtClear | (state_reg == PWR_RESET)),
		.timeout (wdtTimeout)
	);

	// wake sources; software may disable the watchdog to save power
	assign wakeSrc = (wdtTimeout & wdtEn) | portWakeEvt | clrLow | brown;
	assign evt = {sleepExec & (state_reg == PWR_RUN),
	              wdtTimeout & wdtEn,
	              (state_reg == PWR_SLEEP) & wakeSrc};

	// instruction ticks counted in compatible mode, passed in turbo mode
	always_comb begin
		state_next = state_reg;
		to_next    = to_reg;
		pwrDn_next = pwrDn_reg;
		pc_next    = 12'h000;   // load value only means something in reset
		rst_next   = 1'b0;
		clkEn_next = clkEn_reg;
		hold_next  = hold_reg;
		phase_next = phase_reg;
		instr_next = 1'b0;
		case (state_reg)
			PWR_RUN: begin
				clkEn_next = 1'b1;
				if (oscTick) begin
					if (turbo) begin
						instr_next = 1'b1;
					end else begin
						phase_next = 2'(phase_reg + 2'd1);
						instr_next = (phase_reg == 2'(COMPAT_DIVIDE - 1));
					end
				end
				// leaving run drops a tick that would land after the halt
				if (clrLow || brown || (wdtTimeout && wdtEn)) begin
					state_next = PWR_RESET;
					hold_next  = 4'h0;
					instr_next = 1'b0;
				end else if (sleepExec) begin
					state_next = PWR_SLEEP;
					instr_next = 1'b0;
					clkEn_next = sleepClkKeep;
					if (wdtEn) begin
						to_next    = 1'b1;
						pwrDn_next = 1'b0;
					end
				end
			end
			PWR_SLEEP: begin
				if (wakeSrc) begin
					state_next = PWR_RESET;
					to_next    = 1'b1;
					pwrDn_next = 1'b1;
					hold_next  = 4'h0;
				end
			end
			PWR_RESET: begin
				rst_next   = 1'b1;
				clkEn_next = 1'b1;
				pc_next    = PC_TOP;
				phase_next = 2'd0;
				if (hold_reg != 4'(RESET_HOLD_CYC)) begin
					hold_next = 4'(hold_reg + 4'h1);
				end else if (!clrLow && !brown) begin
					state_next = PWR_RUN;
					rst_next   = 1'b0;
				end
			end
			default: state_next = PWR_RESET;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= PWR_RESET;
			to_reg    <= 1'b1;
			pwrDn_reg <= 1'b1;
			pc_reg    <= PC_TOP;
			rst_reg   <= 1'b1;
			clkEn_reg <= 1'b1;
			hold_reg  <= 4'h0;
			phase_reg <= 2'd0;
			instr_reg <= 1'b0;
			rcDiv_reg <= 7'h00;
		end else begin
			state_reg <= state_next;
			to_reg    <= to_next;
			pwrDn_reg <= pwrDn_next;
			pc_reg    <= pc_next;
			rst_reg   <= rst_next;
			clkEn_reg <= clkEn_next;
			hold_reg  <= hold_next;
			phase_reg <= phase_next;
			instr_reg <= instr_next;
			rcDiv_reg <= rcDiv_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign readdata              = rdata_reg;
	assign waitrequest           = wait_reg;
	assign irq                   = irq_reg;
	assign instrCycle            = instr_reg;
	assign coreClkEn             = clkEn_reg;
	assign coreReset             = rst_reg;
	assign pcLoad                = pc_reg;
	assign watchdog_timeout_flag = to_reg;
	assign power_down_flag       = pwrDn_reg;
endmodule : csr_control

//--- verif/csr_control_monitor.sv
// checker for the clock, sleep and reset control ports
// assumes it is bound to csr_control and sees only its ports
`timescale 1ns/1ps
module csr_control_monitor #(
	parameter logic [11:0] PC_TOP = 12'h7FF
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// bus handshake
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	// reset and wake sources
	input wire logic        master_clear_n,
	input wire logic        brownOut,
	input wire logic        portWakeEvt,
	// core side
	input wire logic        instrCycle,
	input wire logic        coreClkEn,
	input wire logic        coreReset,
	input wire logic [11:0] pcLoad,
	input wire logic        watchdog_timeout_flag,
	input wire logic        power_down_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// --------
	// steps of a wake
	// --------
	sequence sAsleep;
		!coreClkEn && !coreReset;
	endsequence
	sequence sWakeReq;
		!master_clear_n || brownOut || portWakeEvt;
	endsequence
	// the sync chain delays pins, so wake is given eight cycles
	a_wake_reset: assert property (sAsleep ##0 sWakeReq |-> ##[1:8] coreReset)
		else $error("no reset after a wake request");
	a_wake_flags: assert property (sAsleep ##1 coreReset |-> ##1
		(watchdog_timeout_flag && power_down_flag) [*3])
		else $error("flags not both set on wake");
	a_pc_top: assert property (coreReset |-> pcLoad == PC_TOP)
		else $error("program counter not at top during reset");
	a_clear_hold: assert property (!master_clear_n [*6] |-> coreReset)
		else $error("clear held low without reset");
	a_brown_reset: assert property ($rose(brownOut) |-> ##[1:8] coreReset)
		else $error("no reset after brown-out");
	a_halt_quiet: assert property (!coreClkEn |-> !instrCycle)
		else $error("instruction tick while halted");
	a_tick_single: assert property (instrCycle |=> !instrCycle)
		else $error("instruction tick longer than a cycle");
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("answer not one cycle after request");
	a_wait_back: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than a cycle");
endmodule : csr_control_monitor

//--- verif/csr_core_model.sv
// core and clock source model facing csr_control
// assumes sleepReq is a one-clock request from the bench
`timescale 1ns/1ps
module csr_core_model (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// from block and bench
	input  wire logic coreReset,
	input  wire logic coreClkEn,
	input  wire logic sleepReq,
	// to the block
	output logic      osc_in_pin,
	output logic      intRcClk,
	output logic      wdtOscClk,
	output logic      sleepExec,
	output logic      wdtClear
);
	logic       running;
	logic [4:0] kickReg;
	logic [4:0] kickNext;
	logic       sleepNext;
	logic       clearNext;
	// sources with phases unrelated to clock, 40 ns period
	initial begin
		osc_in_pin = 1'b0;
		#1.3;
		forever #20 osc_in_pin = ~osc_in_pin;
	end
	initial begin
		intRcClk = 1'b0;
		#3.1;
		forever #20 intRcClk = ~intRcClk;
	end
	// slow watchdog oscillator never stops
	initial begin
		wdtOscClk = 1'b0;
		forever #100 wdtOscClk = ~wdtOscClk;
	end
	// a halted core neither kicks the watchdog nor sleeps
	assign running = coreClkEn && !coreReset;
	always_comb begin
		kickNext = running ? kickReg + 5'h01 : 5'h00;
		clearNext = running && (kickReg == 5'h1F);
		sleepNext = running && sleepReq;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			kickReg <= 5'h00;
			wdtClear <= 1'b0;
			sleepExec <= 1'b0;
		end else begin
			kickReg <= kickNext;
			wdtClear <= clearNext;
			sleepExec <= sleepNext;
		end
	end
endmodule : csr_core_model

//--- verif/csr_control_tb.sv
// self-checking bench for csr_control
// assumes csr_core_model as core and sources, monitor bound below
`timescale 1ns/1ps
module csr_control_tb;
	import csr_pkg::*;
	logic        clock, rst_n, read, write, waitrequest, irq;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, q;
	logic        osc_in_pin, intRcClk, wdtOscClk, master_clear_n;
	logic        brownOut, portWakeEvt, sleepExec, wdtClear, sleepReq;
	logic        instrCycle, coreClkEn, coreReset;
	logic [11:0] pcLoad;
	logic        watchdog_timeout_flag, power_down_flag;
	int          nErrors, nChecks, m, c;
	int          divLog [4] = '{1, 0, 3, 5};
	csr_control #(.PC_TOP(12'h7FF), .WDT_W(2),
		.RC_DIV_LOG2('{3'd1, 3'd0, 3'd3, 3'd5})) csr_control_inst (.*);
	csr_core_model csr_core_model_inst (.*);
	// --------
	// tasks
	// --------
	task automatic stop_test();
		$display("checks %0d errors %0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [31:0] s, e);
		nChecks++;
		if (s !== e) begin
			nErrors++;
			$display("MISMATCH %s exp %0h seen %0h", n, e, s);
		end
	endtask : chk
	// holds the request until the edge that sees waitrequest low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (waitrequest === 1'b0) break;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
		if (i == 20) begin
			nErrors++;
			stop_test();
		end
	endtask : bus
	task automatic rdChk(input logic [3:0] a, input logic [31:0] e, string n);
		bus(1'b0, a, 32'h0);
		chk(n, q, e);
	endtask : rdChk
	// configuration is locked outside program mode
	task automatic setCfg(input logic [3:0] a, input logic [31:0] v);
		bus(1'b1, REG_CONTROL, 32'h1);
		bus(1'b1, a, v);
		bus(1'b1, REG_CONTROL, 32'h0);
	endtask : setCfg
	task automatic waitRst(input logic lvl);
		int i;
		for (i = 0; i < 3000; i++) begin
			if (coreReset === lvl) break;
			@(posedge clock);
		end
		if (i == 3000) begin
			nErrors++;
			stop_test();
		end
	endtask : waitRst
	// phase of the sources is free, so one tick either way is allowed
	task automatic rate(input int n, e, string s);
		c = 0;
		repeat (n) begin
			@(posedge clock);
			if (instrCycle === 1'b1) c++;
		end
		chk(s, c >= e - 1 && c <= e + 1, 1'b1);
	endtask : rate
	task automatic goSleep();
		sleepReq <= 1'b1;
		@(posedge clock);
		sleepReq <= 1'b0;
		repeat (5) @(posedge clock);
	endtask : goSleep
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// --------
	// main sequence
	// --------
	initial begin
		{rst_n, read, write, address, writedata, brownOut} = '0;
		{portWakeEvt, sleepReq, nErrors, nChecks} = '0;
		master_clear_n = 1'b1;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		waitRst(1'b0);
		rdChk(REG_CONFIG, 32'h0C0, "config");
		rdChk(REG_XCONFIG, 32'h001, "xconfig");
		rdChk(REG_STATUS, 32'h3, "status");
		rdChk(4'hF, 32'h0, "unmapped");
		bus(1'b1, REG_CONFIG, 32'h0A5);
		rdChk(REG_CONFIG, 32'h0C0, "locked");
		for (m = 1; m <= 8; m++) begin
			setCfg(REG_CONFIG, 32'h0C0 | m);
			rate(800, 100, "turbo");
			setCfg(REG_CONFIG, 32'h080 | m);
			rate(800, 25, "compat");
		end
		for (m = 0; m < 4; m++) begin
			setCfg(REG_CONFIG, 32'h0C0 | (m << 4));
			rate(1024, 128 >> divLog[m], "rcdiv");
		end
		setCfg(REG_CONFIG, 32'h0C0);
		bus(1'b1, REG_IRQ_MSK, 32'h7);
		goSleep();
		chk("clkEn", coreClkEn, 1'b0);
		rdChk(REG_STATUS, 32'h2, "sleep flags");
		rate(50, 0, "halt");
		waitRst(1'b1);
		chk("pc", pcLoad, 12'h7FF);
		waitRst(1'b0);
		rdChk(REG_STATUS, 32'h3, "wake flags");
		chk("irq", irq, 1'b1);
		rdChk(REG_IRQ_ST, 32'h7, "irq st");
		bus(1'b1, REG_IRQ_ST, 32'h7);
		rdChk(REG_IRQ_ST, 32'h0, "irq clr");
		chk("irq off", irq, 1'b0);
		setCfg(REG_CONFIG, 32'h040);
		bus(1'b1, REG_IRQ_MSK, 32'h0);
		for (m = 0; m < 3; m++) begin
			goSleep();
			repeat (300) @(posedge clock);
			chk("asleep", coreReset, 1'b0);
			portWakeEvt <= (m == 0);
			master_clear_n <= (m != 1);
			brownOut <= (m == 2);
			@(posedge clock);
			portWakeEvt <= 1'b0;
			waitRst(1'b1);
			repeat (2) @(posedge clock);
			chk("held", coreReset, 1'b1);
			master_clear_n <= 1'b1;
			brownOut <= 1'b0;
			waitRst(1'b0);
			rdChk(REG_STATUS, 32'h3, "pin wake");
		end
		chk("masked", irq, 1'b0);
		rdChk(REG_IRQ_ST, 32'h5, "irq sticky");
		setCfg(REG_XCONFIG, 32'h0);
		goSleep();
		chk("clk kept", coreClkEn, 1'b1);
		portWakeEvt <= 1'b1;
		@(posedge clock);
		portWakeEvt <= 1'b0;
		waitRst(1'b1);
		waitRst(1'b0);
		stop_test();
	end
endmodule : csr_control_tb
bind csr_control csr_control_monitor #(.PC_TOP(PC_TOP)) csr_control_monitor_inst (.*);
